// ---- cps_pkg.sv ----
// Constants, field layouts and helpers for the conversion period sequencer.
// Assumes a 32-bit classic Wishbone slave and a 250 MHz master clock.
`default_nettype none

package cps_pkg;

	// Register byte offsets
	localparam logic [7:0] CPS_OFS_PRIMARY = 8'h00;
	localparam logic [7:0] CPS_OFS_SECONDARY = 8'h04;
	localparam logic [7:0] CPS_OFS_TX_TIMING = 8'h08;
	localparam logic [7:0] CPS_OFS_RX_TIMING = 8'h0c;
	localparam logic [7:0] CPS_OFS_STATUS = 8'h10;

	// Word field positions
	localparam int CPS_SEL_LSB = 0;
	localparam int CPS_DAC_LSB = 2;
	localparam int CPS_TX_A_LSB = 9;
	localparam int CPS_TX_W_LSB = 9;
	localparam int CPS_RX_A_LSB = 2;
	localparam int CPS_RX_W_LSB = 2;
	localparam int CPS_FILT_BIT = 9;
	localparam int CPS_ST_CLR_BIT = 6;

	// Secondary word selectors, primary commands
	localparam logic [1:0] CPS_SEL_A = 2'h0;
	localparam logic [1:0] CPS_SEL_ADJ = 2'h1;
	localparam logic [1:0] CPS_SEL_B = 2'h2;
	localparam logic [1:0] CPS_SEL_CTRL = 2'h3;
	localparam logic [1:0] CPS_CMD_PLUS = 2'h1;
	localparam logic [1:0] CPS_CMD_MINUS = 2'h2;

	// Reset values and limits
	localparam logic [4:0] CPS_RST_A = 5'h12;
	localparam logic [5:0] CPS_RST_ADJ = 6'h01;
	localparam logic [5:0] CPS_RST_B = 6'h12;
	localparam logic [15:0] CPS_RST_CTRL = 16'h02e4;
	localparam logic [5:0] CPS_B_MIN = 6'h0f;
	localparam logic [5:0] CPS_B_FIX = 6'h12;
	localparam logic [4:0] CPS_A_DEAD = 5'h01;
	localparam logic [4:0] CPS_A_MIN_WORD = 5'h04;
	localparam logic [4:0] CPS_A_MIN_BYTE = 5'h05;
	localparam logic signed [7:0] CPS_MOD64 = 8'sh40;
	localparam logic [5:0] CPS_ONE = 6'h01;

	// Closest allowed spacing of conversion frame syncs
	localparam int CPS_CLK_PS = 4000;
	localparam int CPS_MIN_GAP_PS = 40000000;
	localparam int CPS_MIN_GAP_CYC = (CPS_MIN_GAP_PS + CPS_CLK_PS - 1) / CPS_CLK_PS;

	// Signed sum of an A value and its adjust value, added or subtracted
	function automatic logic signed [7:0] cps_adj_sum(input logic [4:0] a,
		input logic [5:0] adj, input logic neg);
		logic signed [7:0] s_adj;
		s_adj = $signed({{2{adj[5]}}, adj});
		return neg ? $signed({3'h0, a}) - s_adj : $signed({3'h0, a}) + s_adj;
	endfunction : cps_adj_sum

	// Count loaded for an adjusted subperiod, with repair of illegal sums
	function automatic logic [5:0] cps_adj_load(input logic [4:0] a,
		input logic [5:0] adj, input logic neg);
		logic signed [7:0] s;
		logic signed [7:0] w;
		s = cps_adj_sum(a, adj, neg);
		w = s + CPS_MOD64;
		if (s == 8'sh00 || s == 8'sh01)
			return {1'b0, a};
		else if (s < 8'sh00)
			return w[5:0];
		else
			return s[5:0];
	endfunction : cps_adj_load

endpackage : cps_pkg

`default_nettype wire

// ---- cps_sequencer.sv ----
// Conversion period sequencer: transmit and receive period counters,
// adjust scheduling and fatal-value handling behind a Wishbone slave.
// Assumes synchronous inputs on mclk and a master that holds requests until ack.
//
// Function
// - Adjusted transmit sum of 0 or 1 loads plain transmit A instead.
// - Negative transmit sum gets 0x40 added before loading the counter.
// - Adjusted receive sum of 0 or 1 loads plain receive A instead.
// - Negative receive sum gets 0x40 added before loading the counter.
// - Transmit or receive A of 0 or 1 shuts down until reset.
// - A below 4 in word mode or 5 in byte mode locks serial port.
// - Transmit B written below 15 is stored as 0x12.
// - Receive B written below 15 is stored as 0x12.
// - Without host communication the last converter output value is held.
// - One adjust command adjusts exactly one transmit and one receive period.
// - Adjustment applies in the last subperiod of the conversion period.
// - Adjust command adjusts the transmit period currently running.
// - Receive adjust lands in current receive period if time, else next.
// - Receive part ignored when a receive adjust is already scheduled.
// - Transmit values and control from a secondary word apply this period.
// - Receive values apply in current receive period if time, else next.
// - Further receive values within an applying receive period are discarded.
// - Control bit nine inserts or bypasses the correction filter.
// - Reset sets all A and B values to 0x12, adjusts to 0x01.
// - A values are five-bit unsigned, adjust values six-bit two's complement.
// - Width select high means sixteen-bit transfers, low means byte transfers.
//
// Decided for this implementation: register access over Wishbone and the address map.
`default_nettype none

module cps_sequencer
	import cps_pkg::*;
#(
	parameter int CLK_DIV = 20,
	parameter int MIN_GAP = CPS_MIN_GAP_CYC,
	parameter int GAP_W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Transfer width strap
	input wire logic word_mode,
	// Converter side
	output logic [13:0] dac_out,
	output logic filter_insert,
	output logic transmit_frame_sync,
	output logic receive_frame_sync,
	output logic shutdown,
	output logic serial_lockout
);

	generate
		if (CLK_DIV < 2 || CLK_DIV > 255 || GAP_W < 2 || GAP_W > 31 ||
			MIN_GAP < 1 || MIN_GAP >= (1 << GAP_W)) begin : g_bad_param
			$error("cps_sequencer: parameter out of range");
		end
	endgenerate

	localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);
	localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(MIN_GAP);
	localparam logic [GAP_W-1:0] GAP_MAX = '1;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [13:0] dac;
		logic [15:0] ctrl;
		logic [4:0] ta;
		logic [5:0] tadj;
		logic [5:0] tb;
		logic [4:0] ra;
		logic [5:0] radj;
		logic [5:0] rb;
		logic [4:0] ra_n;
		logic [5:0] radj_n;
		logic [5:0] rb_n;
		logic rx_new;
		logic rx_lock;
		logic [7:0] div;
		logic [5:0] tx_cnt;
		logic [5:0] tx_sub;
		logic [5:0] rx_cnt;
		logic [5:0] rx_sub;
		logic tx_adj_pend;
		logic tx_adj_neg;
		logic rx_adj_pend;
		logic rx_adj_neg;
		logic shutdown;
		logic lockout;
		logic too_close;
		logic [GAP_W-1:0] gap;
		logic tx_fs;
		logic rx_fs;
	} cps_state_t;

	cps_state_t st;
	cps_state_t next_st;

	logic req;
	logic wr;
	logic port_wr;
	logic tick;
	logic run;
	logic tx_end;
	logic tx_conv_end;
	logic [5:0] tx_sub_next;
	logic tx_load_adj;
	logic signed [7:0] tx_sum;
	logic rx_end;
	logic rx_conv_end;
	logic [5:0] rx_sub_next;
	logic rx_load_adj;
	logic signed [7:0] rx_sum;
	logic rx_lock_now;
	logic [4:0] a_min;
	logic [1:0] wsel;
	logic [15:0] wdat;

	assign req = cyc_i & stb_i & ~st.ack;
	// Partial writes are dropped: every field spans the low two byte lanes
	assign wr = req & we_i & sel_i[0] & sel_i[1];
	// A locked serial port takes no more words
	assign port_wr = wr & ~st.lockout;
	assign wdat = dat_i[15:0];
	assign wsel = wdat[CPS_SEL_LSB +: 2];
	assign tick = (st.div == DIV_LAST);
	assign run = tick & ~st.shutdown;
	assign a_min = word_mode ? CPS_A_MIN_WORD : CPS_A_MIN_BYTE;

	// Subperiod ends; the last subperiod of a conversion carries the adjust
	assign tx_end = run & (st.tx_cnt <= CPS_ONE);
	assign tx_conv_end = tx_end & (st.tx_sub <= CPS_ONE);
	assign tx_sub_next = tx_conv_end ? st.tb : st.tx_sub - CPS_ONE;
	assign tx_load_adj = tx_end & (tx_sub_next == CPS_ONE) & st.tx_adj_pend;
	assign tx_sum = cps_adj_sum(st.ta, st.tadj, st.tx_adj_neg);

	assign rx_end = run & (st.rx_cnt <= CPS_ONE);
	assign rx_conv_end = rx_end & (st.rx_sub <= CPS_ONE);
	assign rx_sub_next = rx_conv_end ? st.rb : st.rx_sub - CPS_ONE;
	assign rx_load_adj = rx_end & (rx_sub_next == CPS_ONE) & st.rx_adj_pend;
	assign rx_sum = cps_adj_sum(st.ra, st.radj, st.rx_adj_neg);
	assign rx_lock_now = rx_conv_end ? 1'b0 : st.rx_lock;

	always_comb begin
		next_st = st;
		next_st.ack = req;
		next_st.tx_fs = 1'b0;
		next_st.rx_fs = 1'b0;
		next_st.div = tick ? 8'h00 : st.div + 8'h01;
		if (st.gap != GAP_MAX)
			next_st.gap = st.gap + GAP_W'(1);

		// Transmit period counter
		if (tx_end) begin
			next_st.tx_sub = tx_sub_next;
			if (tx_load_adj) begin
				next_st.tx_cnt = cps_adj_load(st.ta, st.tadj, st.tx_adj_neg);
				next_st.tx_adj_pend = 1'b0;
			end else begin
				next_st.tx_cnt = {1'b0, st.ta};
			end
			if (tx_conv_end) begin
				next_st.tx_fs = 1'b1;
				next_st.gap = '0;
				// Host spacing slip is only flagged; the converter cannot refuse it
				if (st.gap < GAP_MIN)
					next_st.too_close = 1'b1;
			end
		end else if (run) begin
			next_st.tx_cnt = st.tx_cnt - CPS_ONE;
		end

		// Receive period counter
		if (rx_end) begin
			next_st.rx_sub = rx_sub_next;
			if (rx_load_adj) begin
				next_st.rx_cnt = cps_adj_load(st.ra, st.radj, st.rx_adj_neg);
				next_st.rx_adj_pend = 1'b0;
			end else begin
				next_st.rx_cnt = {1'b0, st.ra};
			end
			next_st.rx_fs = rx_conv_end;
			next_st.rx_lock = rx_lock_now;
			// Pending values land at the next boundary, this period or the next
			if (st.rx_new && !rx_lock_now) begin
				next_st.ra = st.ra_n;
				next_st.radj = st.radj_n;
				next_st.rb = st.rb_n;
				next_st.rx_new = 1'b0;
				next_st.rx_lock = 1'b1;
			end
		end else if (run) begin
			next_st.rx_cnt = st.rx_cnt - CPS_ONE;
		end

		// Status write: clear spacing flag, but a fresh slip in the same cycle wins
		if (wr && adr_i == CPS_OFS_STATUS && wdat[CPS_ST_CLR_BIT] && !(tx_conv_end &&
			st.gap < GAP_MIN))
			next_st.too_close = 1'b0;

		// Primary word: converter data and adjust command, taken when written
		if (port_wr && adr_i == CPS_OFS_PRIMARY) begin
			next_st.dac = wdat[CPS_DAC_LSB +: 14];
			if (wsel == CPS_CMD_PLUS || wsel == CPS_CMD_MINUS) begin
				next_st.tx_adj_pend = 1'b1;
				next_st.tx_adj_neg = (wsel == CPS_CMD_MINUS);
				// Current receive period if its last subperiod is not loaded yet
				if (!next_st.rx_adj_pend) begin
					next_st.rx_adj_pend = 1'b1;
					next_st.rx_adj_neg = (wsel == CPS_CMD_MINUS);
				end
			end
		end

		// Secondary word: transmit side at once, receive side through the shadow
		if (port_wr && adr_i == CPS_OFS_SECONDARY) begin
			unique case (wsel)
				CPS_SEL_A: begin
					next_st.ta = wdat[CPS_TX_A_LSB +: 5];
					next_st.ra_n = wdat[CPS_RX_A_LSB +: 5];
				end
				CPS_SEL_ADJ: begin
					next_st.tadj = wdat[CPS_TX_W_LSB +: 6];
					next_st.radj_n = wdat[CPS_RX_W_LSB +: 6];
				end
				CPS_SEL_B: begin
					next_st.tb = (wdat[CPS_TX_W_LSB +: 6] < CPS_B_MIN) ? CPS_B_FIX :
						wdat[CPS_TX_W_LSB +: 6];
					next_st.rb_n = (wdat[CPS_RX_W_LSB +: 6] < CPS_B_MIN) ? CPS_B_FIX :
						wdat[CPS_RX_W_LSB +: 6];
				end
				CPS_SEL_CTRL: begin
					next_st.ctrl = wdat;
				end
			endcase
			// Receive values arriving after an apply in this period are lost
			if (wsel != CPS_SEL_CTRL && !next_st.rx_lock) begin
				if (!next_st.rx_new) begin
					next_st.ra_n = (wsel == CPS_SEL_A) ? wdat[CPS_RX_A_LSB +: 5] : st.ra;
					next_st.radj_n = (wsel == CPS_SEL_ADJ) ? wdat[CPS_RX_W_LSB +: 6] :
						st.radj;
					next_st.rb_n = (wsel == CPS_SEL_B) ? next_st.rb_n : st.rb;
				end
				next_st.rx_new = 1'b1;
			end else begin
				next_st.ra_n = st.ra_n;
				next_st.radj_n = st.radj_n;
				next_st.rb_n = st.rb_n;
			end
		end

		// Fatal values are sticky until reset
		if (st.ta <= CPS_A_DEAD || st.ra <= CPS_A_DEAD)
			next_st.shutdown = 1'b1;
		if (st.ta < a_min || st.ra < a_min)
			next_st.lockout = 1'b1;

		// Read data, zero for unmapped offsets
		next_st.rdat = 32'h0000_0000;
		if (req && !we_i) begin
			unique case (adr_i)
				CPS_OFS_PRIMARY: next_st.rdat = {16'h0000, st.dac, 2'h0};
				CPS_OFS_SECONDARY: next_st.rdat = {16'h0000, st.ctrl};
				CPS_OFS_TX_TIMING: next_st.rdat = {15'h0000, st.tb, st.tadj, st.ta};
				CPS_OFS_RX_TIMING: next_st.rdat = {15'h0000, st.rb, st.radj, st.ra};
				CPS_OFS_STATUS: next_st.rdat = {25'h0000000, st.too_close, st.rx_lock,
					st.rx_new, st.rx_adj_pend, st.tx_adj_pend, st.lockout, st.shutdown};
				default: next_st.rdat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
			st.ctrl <= CPS_RST_CTRL;
			st.ta <= CPS_RST_A;
			st.tadj <= CPS_RST_ADJ;
			st.tb <= CPS_RST_B;
			st.ra <= CPS_RST_A;
			st.radj <= CPS_RST_ADJ;
			st.rb <= CPS_RST_B;
			st.ra_n <= CPS_RST_A;
			st.radj_n <= CPS_RST_ADJ;
			st.rb_n <= CPS_RST_B;
			st.tx_cnt <= {1'b0, CPS_RST_A};
			st.tx_sub <= CPS_RST_B;
			st.rx_cnt <= {1'b0, CPS_RST_A};
			st.rx_sub <= CPS_RST_B;
		end else begin
			st <= next_st;
		end
	end

	// Output value held whenever the host stops sending
	assign dac_out = st.dac;
	assign filter_insert = st.ctrl[CPS_FILT_BIT];
	assign transmit_frame_sync = st.tx_fs;
	assign receive_frame_sync = st.rx_fs;
	assign shutdown = st.shutdown;
	assign serial_lockout = st.lockout;
	assign dat_o = st.rdat;
	assign ack_o = st.ack;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Counter repair on adjusted loads
	chk_tx_small_sum: assert property (tx_load_adj
		&& (tx_sum == 8'sh00 || tx_sum == 8'sh01) |=> st.tx_cnt == {1'b0, $past(st.ta)})
		else $error("transmit small sum not repaired");
	chk_tx_neg_sum: assert property (tx_load_adj && tx_sum < 8'sh00
		|=> st.tx_cnt == 6'($past(tx_sum) + CPS_MOD64))
		else $error("transmit negative sum not wrapped");
	chk_rx_small_sum: assert property (rx_load_adj
		&& (rx_sum == 8'sh00 || rx_sum == 8'sh01) |=> st.rx_cnt == {1'b0, $past(st.ra)})
		else $error("receive small sum not repaired");
	chk_rx_neg_sum: assert property (rx_load_adj && rx_sum < 8'sh00
		|=> st.rx_cnt == 6'($past(rx_sum) + CPS_MOD64))
		else $error("receive negative sum not wrapped");

	// Fatal values and what they block
	chk_shutdown_frozen: assert property (shutdown |=> shutdown
		&& !transmit_frame_sync && $stable(st.tx_cnt) && $stable(st.rx_cnt))
		else $error("counters move after shutdown");
	chk_shutdown_set: assert property (st.ta <= CPS_A_DEAD || st.ra <= CPS_A_DEAD
		|=> shutdown)
		else $error("dead A value did not shut down");
	chk_lockout_dac_hold: assert property (serial_lockout |=> serial_lockout
		&& $stable(dac_out))
		else $error("locked port changed converter data");
	chk_lockout_set: assert property (st.ta < a_min || st.ra < a_min
		|=> serial_lockout)
		else $error("short A value did not lock the port");
	chk_locked_timing: assert property (serial_lockout && wr
		&& adr_i == CPS_OFS_SECONDARY |=> $stable(st.ta) && $stable(st.tb) && $stable(st.ctrl))
		else $error("locked port took timing values");
	chk_tx_b_fix: assert property (port_wr && adr_i == CPS_OFS_SECONDARY
		&& wsel == CPS_SEL_B && wdat[CPS_TX_W_LSB +: 6] < CPS_B_MIN |=> st.tb == CPS_B_FIX)
		else $error("short transmit B kept");
	chk_rx_b_fix: assert property (port_wr && adr_i == CPS_OFS_SECONDARY
		&& wsel == CPS_SEL_B && !next_st.rx_lock && wdat[CPS_RX_W_LSB +: 6] < CPS_B_MIN
		|=> st.rb_n == CPS_B_FIX)
		else $error("short receive B kept");
	chk_spacing_flag: assert property (tx_conv_end && st.gap < GAP_MIN
		|=> st.too_close)
		else $error("close frame syncs not flagged");

	// Adjust scheduling and receive value hand-over
	chk_tx_adj_once: assert property (tx_load_adj
		&& !(port_wr && adr_i == CPS_OFS_PRIMARY) |=> !st.tx_adj_pend)
		else $error("transmit adjust kept after use");
	chk_tx_adj_taken: assert property (port_wr && adr_i == CPS_OFS_PRIMARY
		&& wsel == CPS_CMD_MINUS |=> st.tx_adj_pend && st.tx_adj_neg)
		else $error("minus command not scheduled");
	chk_rx_adj_ignored: assert property (st.rx_adj_pend && !rx_load_adj
		&& port_wr && adr_i == CPS_OFS_PRIMARY |=> st.rx_adj_pend && $stable(st.rx_adj_neg))
		else $error("second receive adjust not ignored");
	chk_rx_discard: assert property (st.rx_lock && !rx_conv_end && !st.rx_new
		&& port_wr && adr_i == CPS_OFS_SECONDARY && wsel != CPS_SEL_CTRL |=> !st.rx_new)
		else $error("receive values taken in locked period");
	chk_filter_route: assert property (port_wr && adr_i == CPS_OFS_SECONDARY
		&& wsel == CPS_SEL_CTRL |=> filter_insert == $past(wdat[CPS_FILT_BIT]))
		else $error("filter select does not follow control");

	// Register bus answers each request once
	chk_ack_single: assert property (ack_o
		|=> !ack_o)
		else $error("acknowledge held longer than one cycle");

endmodule : cps_sequencer

`default_nettype wire

// ---- cps_host_model.sv ----
// Host model: classic Wishbone master issuing single read and write cycles.
// Assumes a slave that answers every request with a one-cycle ack.
`default_nettype none

module cps_host_model (
	// Clock
	input wire logic mclk,
	// Wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat_w,
	input wire logic [31:0] dat_r,
	input wire logic ack
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_w = 32'h0;
	end

	// Request held until ack is sampled; bus idles a cycle before the next
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_w <= d;
		@(posedge mclk);
		while (ack !== 1'b1) @(posedge mclk);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : xfer

endmodule : cps_host_model

`default_nettype wire

// ---- cps_sequencer_tb.sv ----
// Testbench for the conversion period sequencer, driven through the host model.
// Assumes the tick divider is shrunk to 2 so a full conversion takes 648 cycles.
`default_nettype none

module cps_sequencer_tb
	import cps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Periods stay far above the frame sync spacing limit of 50 cycles
	localparam int DIV = 2;
	localparam int NORM = 18 * 18 * DIV;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic word_mode = 1'b1;
	logic cyc, stb, we, ack, filter_insert, tx_fs, rx_fs, shutdown, serial_lockout;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, q;
	logic [13:0] dac_out;
	int err_count = 0;
	int checked = 0;
	int tx_cnt = 0;
	int rx_cnt = 0;
	int tx_len = 0;
	int rx_len = 0;

	always #2 mclk = ~mclk;

	cps_sequencer #(.CLK_DIV(DIV), .MIN_GAP(50), .GAP_W(16)) cps_sequencer_i (.mclk(mclk),
		.rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .word_mode(word_mode), .dac_out(dac_out),
		.filter_insert(filter_insert), .transmit_frame_sync(tx_fs),
		.receive_frame_sync(rx_fs), .shutdown(shutdown), .serial_lockout(serial_lockout));

	cps_host_model cps_host_model_i (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack));

	// Spacing of frame sync pulses in cycles
	always @(posedge mclk) begin
		tx_cnt <= (tx_fs === 1'b1) ? 1 : tx_cnt + 1;
		rx_cnt <= (rx_fs === 1'b1) ? 1 : rx_cnt + 1;
		if (tx_fs === 1'b1) tx_len <= tx_cnt;
		if (rx_fs === 1'b1) rx_len <= rx_cnt;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cps_host_model_i.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd_cmp(input string what, input logic [7:0] a, input logic [31:0] exp);
		cps_host_model_i.xfer(1'b0, a, 32'h0, q);
		cmp(what, exp, q);
	endtask : rd_cmp

	task automatic reset_dut();
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
	endtask : reset_dut

	// Waits for a frame sync pulse; gives up after 2000 cycles if none comes
	task automatic wait_fs(input logic rx);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((rx ? rx_fs : tx_fs) !== 1'b1 && n < 2000);
		// A pulse that never comes is a failure, not a silent return
		if ((rx ? rx_fs : tx_fs) !== 1'b1) begin
			err_count++;
			$display("MISMATCH frame sync expected 1 seen 0");
		end
		#1;
	endtask : wait_fs

	task automatic t_reset_vals();
		rd_cmp("tx timing", 8'h08, 32'h9032);
		rd_cmp("rx timing", 8'h0c, 32'h9032);
		rd_cmp("control", 8'h04, 32'h2e4);
		rd_cmp("status", 8'h10, 32'h0);
		rd_cmp("unmapped", 8'h20, 32'h0);
		cmp("filter", 32'h1, {31'h0, filter_insert});
	endtask : t_reset_vals

	// Sum of 1 keeps plain A; sum of -2 becomes 62
	task automatic t_adjust();
		logic [5:0] adj [4] = '{6'h2f, 6'h11, 6'h2c, 6'h14};
		logic [1:0] cmd [4] = '{CPS_CMD_PLUS, CPS_CMD_MINUS, CPS_CMD_PLUS, CPS_CMD_MINUS};
		int load [4] = '{18, 18, 62, 62};
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, {17'h0, adj[i], 1'b0, adj[i], 2'b01});
			wait_fs(1'b0);
			wr(8'h00, {30'h0, cmd[i]});
			wait_fs(1'b0);
			cmp("tx adjusted", (17 * 18 + load[i]) * DIV, tx_len);
			cmp("rx adjusted", (17 * 18 + load[i]) * DIV, rx_len);
			wait_fs(1'b0);
			cmp("tx after adjust", NORM, tx_len);
		end
	endtask : t_adjust

	task automatic t_b_fix();
		wr(8'h04, 32'h1e3a);
		rd_cmp("tx b 15", 8'h08, 32'h7832);
		repeat (40) @(posedge mclk);
		rd_cmp("rx b 14", 8'h0c, 32'h9032);
		wr(8'h04, 32'h1c3e);
		rd_cmp("tx b 14", 8'h08, 32'h9032);
		repeat (40) @(posedge mclk);
		rd_cmp("rx second set", 8'h0c, 32'h9032);
		wait_fs(1'b1);
		wr(8'h04, 32'h1c3e);
		repeat (40) @(posedge mclk);
		rd_cmp("rx b 15", 8'h0c, 32'h7832);
	endtask : t_b_fix

	task automatic t_filter();
		wr(8'h04, 32'h00e7);
		repeat (3) @(posedge mclk);
		cmp("filter off", 32'h0, {31'h0, filter_insert});
		rd_cmp("control", 8'h04, 32'h00e7);
		wr(8'h04, 32'h02e7);
		repeat (3) @(posedge mclk);
		cmp("filter on", 32'h1, {31'h0, filter_insert});
	endtask : t_filter

	task automatic t_lockout();
		wr(8'h00, {16'h0, 14'h1abc, 2'b00});
		wr(8'h04, 32'h0848);
		repeat (40) @(posedge mclk);
		cmp("dac", 32'h1abc, {18'h0, dac_out});
		cmp("lockout word 4", 32'h0, {31'h0, serial_lockout});
		@(posedge mclk);
		word_mode <= 1'b0;
		repeat (4) @(posedge mclk);
		cmp("lockout byte 4", 32'h1, {31'h0, serial_lockout});
		cmp("no shutdown", 32'h0, {31'h0, shutdown});
		wr(8'h00, {16'h0, 14'h0555, 2'b00});
		repeat (3) @(posedge mclk);
		cmp("dac held", 32'h1abc, {18'h0, dac_out});
		word_mode <= 1'b1;
		reset_dut();
		cmp("lockout cleared", 32'h0, {31'h0, serial_lockout});
	endtask : t_lockout

	task automatic t_shutdown();
		wr(8'h04, 32'h0248);
		repeat (4) @(posedge mclk);
		cmp("shutdown", 32'h1, {31'h0, shutdown});
		reset_dut();
		cmp("shutdown cleared", 32'h0, {31'h0, shutdown});
		rd_cmp("tx timing", 8'h08, 32'h9032);
	endtask : t_shutdown

	initial begin
		reset_dut();
		t_reset_vals();
		t_adjust();
		reset_dut();
		t_b_fix();
		t_filter();
		t_lockout();
		t_shutdown();
		conclude();
	end

	// Whole run needs about 9000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		conclude();
	end

endmodule : cps_sequencer_tb

`default_nettype wire
